// >>> logic/bcie_pkg.sv
// constants and types for the controller enable and configuration registers
// Operation
// - an enabled event raises the host interrupt; masked events raise none
// - enable bits 13,12,8,7,6,4,3,2,1,0 map to their listed events
// - enable bit 9 is read/write but never raises an interrupt
// - unused enable bits read zero; enable register resets to all zeros
// - configuration one drives the controller only while bit 15 is zero; the code checks bit 15 only at a start from idle
// - configuration bit 14 is held at zero
// - bit 13 selects memory area A (0) or B (1)
// - bit 12 halts at end of a message with an error unless retry succeeded
// - bit 11 halts at end of a frame that had an error
// - bit 10 stops messages on unexpected unmasked status bits
// - bit 9 with auto repeat starts no further frames after bad status
// - bit 8 with enhanced mode repeats frames; otherwise the host or an enabled external trigger edge starts each frame
// - bit 7 enables external trigger on its rising edge
// - bit 6 with auto repeat retriggers frames from a 100 us step counter
// - bit 5 uses descriptor gap in microseconds, else about ten microseconds
// - bit 4 enables retries for messages whose control bit 8 is set
// - bit 3 allows two retries, otherwise one
// - bit 2 reads one from start until messages end or a halt
// - bit 1 reads one from first message start to last message end
// - bit 0 reads one during each message
package bcie_pkg;
  localparam logic [4:0] ADDR_IEN = 5'h00;
  localparam logic [4:0] ADDR_CFG1 = 5'h01;
  localparam logic [4:0] ADDR_START = 5'h03;
  localparam logic [15:0] IEN_RST = 16'h0000;
  localparam logic [15:0] IEN_WMASK = 16'h33df;
  localparam logic [15:0] IEN_EVMASK = 16'h31df;
  localparam logic [15:0] CFG1_RST = 16'h0000;
  localparam logic [15:0] CFG1_WMASK = 16'hbff8;
  localparam int EV_RETRY = 8;
  localparam int EV_BC_EOM = 4;
  localparam int EV_BC_EOF = 3;
  localparam int C_ENH_RT = 15;
  localparam int C_FIX0 = 14;
  localparam int C_AREA = 13;
  localparam int C_ERR_EOM = 12;
  localparam int C_ERR_EOF = 11;
  localparam int C_STS_EOM = 10;
  localparam int C_STS_EOF = 9;
  localparam int C_AUTO = 8;
  localparam int C_EXT = 7;
  localparam int C_INT = 6;
  localparam int C_GAP = 5;
  localparam int C_RETRY = 4;
  localparam int C_TWICE = 3;
  localparam int C_RUN = 2;
  localparam int C_FRAME = 1;
  localparam int C_MSG = 0;
  localparam int S_LAUNCH = 1;
  localparam int CLK_NS = 10;
  localparam int US_NS = 1000;
  localparam int STEP_NS = 100000;
  localparam int GAP_DEF_US = 10;
  localparam int US_CYC = US_NS / CLK_NS;
  localparam int STEP_CYC = STEP_NS / CLK_NS;
  typedef struct packed {
    logic error;
    logic unexp_sts;
    logic retry_ctl;
    logic last;
  } bcie_msg_rpt_t;
endpackage

// >>> logic/bcie_regs.sv
// interrupt enable and controller configuration registers with frame sequencer
`timescale 1ns/10ps
module bcie_regs #(
  parameter int STEP_CYCLES = bcie_pkg::STEP_CYC
) (
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic i_cs_n,
  input wire logic i_rd_n,
  input wire logic i_wr_n,
  input wire logic [4:0] i_addr,
  input wire logic [15:0] i_wdata,
  output logic [15:0] o_rdata,
  output logic o_rdata_oe,
  input wire logic [15:0] i_events,
  input wire logic i_enhanced_mode_select_bit,
  input wire logic i_ext_trig,
  input wire logic [15:0] i_frame_len,
  input wire logic [15:0] i_gap,
  input wire logic i_msg_done,
  input wire bcie_pkg::bcie_msg_rpt_t i_msg_rpt,
  output logic [15:0] o_cfg1,
  output logic o_msg_start,
  output logic o_irq
);
  typedef enum logic [1:0] {ST_IDLE, ST_GAP, ST_MSG, ST_WAIT} bcie_st_t;
  bcie_st_t st;
  logic [15:0] ien;
  logic wr_d, rd_act, wr_stb, start_cmd, bc_mode;
  logic running, frame_act, msg_act, retrying, frame_err, frame_sts;
  logic [1:0] retries;
  logic ext_d, ext_rise, us_tick, step_tick, frame_due;
  logic [$clog2(STEP_CYCLES)-1:0] step_div;
  logic [6:0] us_div;
  logic [15:0] gap_cnt, frame_cnt;
  logic failed, do_retry, halt_msg, halt_frame, auto_on, trig_go;
  logic [15:0] ev_eff;

  // host strobes sampled synchronously; a write acts on the falling edge of write
  assign wr_stb = !i_cs_n && !i_wr_n && wr_d;
  assign rd_act = !i_cs_n && !i_rd_n;
  assign start_cmd = wr_stb && i_addr == bcie_pkg::ADDR_START
                     && i_wdata[bcie_pkg::S_LAUNCH];
  assign bc_mode = !o_cfg1[bcie_pkg::C_ENH_RT];
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wr_d <= 1'b1;
      ext_d <= 1'b0;
    end else begin
      wr_d <= i_wr_n || i_cs_n;
      ext_d <= i_ext_trig;
    end
  end

  // enable register: only assigned bits hold, bit 9 included
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ien <= bcie_pkg::IEN_RST;
    end else if (wr_stb && i_addr == bcie_pkg::ADDR_IEN) begin
      ien <= i_wdata & bcie_pkg::IEN_WMASK;
    end
  end

  // configuration: writable fields plus live status in bits 2..0, bit 14 stays zero
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_cfg1 <= bcie_pkg::CFG1_RST;
    end else begin
      if (wr_stb && i_addr == bcie_pkg::ADDR_CFG1) begin
        o_cfg1[15:3] <= i_wdata[15:3] & bcie_pkg::CFG1_WMASK[15:3];
      end
      o_cfg1[bcie_pkg::C_RUN] <= running;
      o_cfg1[bcie_pkg::C_FRAME] <= frame_act;
      o_cfg1[bcie_pkg::C_MSG] <= msg_act;
    end
  end

  // read port: registered data, unmapped addresses read zero
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rdata <= 16'h0000;
      o_rdata_oe <= 1'b0;
    end else begin
      o_rdata_oe <= rd_act;
      case (i_addr)
        bcie_pkg::ADDR_IEN: o_rdata <= ien;
        bcie_pkg::ADDR_CFG1: o_rdata <= o_cfg1;
        default: o_rdata <= 16'h0000;
      endcase
    end
  end

  // interrupt: own retry/eom/eof events merged in; bit 9 has no event behind it
  always_comb begin
    ev_eff = i_events;
    ev_eff[bcie_pkg::EV_RETRY] = i_events[bcie_pkg::EV_RETRY] || do_retry;
    ev_eff[bcie_pkg::EV_BC_EOM] = i_events[bcie_pkg::EV_BC_EOM] || (st == ST_MSG && i_msg_done);
    ev_eff[bcie_pkg::EV_BC_EOF] = i_events[bcie_pkg::EV_BC_EOF]
                                  || (st == ST_MSG && i_msg_done && i_msg_rpt.last);
  end
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(ev_eff & ien & bcie_pkg::IEN_EVMASK);
    end
  end

  // 1 us and 100 us timebases; free running so gaps may be up to one tick short
  assign us_tick = us_div == 7'(bcie_pkg::US_CYC - 1);
  assign step_tick = step_div == ($clog2(STEP_CYCLES))'(STEP_CYCLES - 1);
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      us_div <= 7'h00;
      step_div <= '0;
    end else begin
      us_div <= us_tick ? 7'h00 : us_div + 7'h01;
      step_div <= step_tick ? '0 : step_div + ($clog2(STEP_CYCLES))'(1);
    end
  end

  // message outcome decode
  assign ext_rise = i_ext_trig && !ext_d && o_cfg1[bcie_pkg::C_EXT];
  assign failed = i_msg_rpt.error || i_msg_rpt.unexp_sts;
  assign do_retry = st == ST_MSG && i_msg_done && failed && o_cfg1[bcie_pkg::C_RETRY]
                    && i_msg_rpt.retry_ctl && retries != 2'd0;
  assign halt_msg = (i_msg_rpt.error && o_cfg1[bcie_pkg::C_ERR_EOM])
                    || (i_msg_rpt.unexp_sts && o_cfg1[bcie_pkg::C_STS_EOM]);
  assign auto_on = o_cfg1[bcie_pkg::C_AUTO] && i_enhanced_mode_select_bit;
  assign halt_frame = ((frame_err || (i_msg_rpt.error && !do_retry))
                       && o_cfg1[bcie_pkg::C_ERR_EOF])
                      || ((frame_sts || (i_msg_rpt.unexp_sts && !do_retry))
                          && o_cfg1[bcie_pkg::C_STS_EOF] && auto_on);
  assign frame_due = o_cfg1[bcie_pkg::C_INT] && frame_cnt >= i_frame_len;
  assign trig_go = ext_rise || frame_due
                   || !(o_cfg1[bcie_pkg::C_EXT] || o_cfg1[bcie_pkg::C_INT]);

  // frame length counter in 100 us steps, restarted at every frame start
  // frame_act rises with the start pulse, so the lagged status bit marks a new frame
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      frame_cnt <= 16'h0000;
    end else if (o_msg_start && !o_cfg1[bcie_pkg::C_FRAME]) begin
      frame_cnt <= 16'h0000;
    end else if (step_tick && frame_cnt != 16'hffff) begin
      frame_cnt <= frame_cnt + 16'h0001;
    end
  end

  // sequencer: idle, inter-message gap, message in flight, wait for next frame
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st <= ST_IDLE;
      running <= 1'b0;
      frame_act <= 1'b0;
      msg_act <= 1'b0;
      o_msg_start <= 1'b0;
      retrying <= 1'b0;
      retries <= 2'd0;
      frame_err <= 1'b0;
      frame_sts <= 1'b0;
      gap_cnt <= 16'h0000;
    end else begin
      o_msg_start <= 1'b0;
      case (st)
        ST_IDLE: begin
          if (bc_mode && (start_cmd || ext_rise)) begin
            st <= ST_MSG;
            running <= 1'b1;
            frame_act <= 1'b1;
            msg_act <= 1'b1;
            o_msg_start <= 1'b1;
            frame_err <= 1'b0;
            frame_sts <= 1'b0;
            retries <= o_cfg1[bcie_pkg::C_TWICE] ? 2'd2 : 2'd1;
          end
        end
        ST_GAP: begin
          if (gap_cnt == 16'h0000) begin
            st <= ST_MSG;
            msg_act <= 1'b1;
            frame_act <= 1'b1;
            o_msg_start <= 1'b1;
          end else if (us_tick) begin
            gap_cnt <= gap_cnt - 16'h0001;
          end
        end
        ST_MSG: begin
          if (i_msg_done) begin
            msg_act <= 1'b0;
            st <= ST_GAP;
            gap_cnt <= o_cfg1[bcie_pkg::C_GAP] ? i_gap : 16'(bcie_pkg::GAP_DEF_US);
            if (do_retry) begin
              retrying <= 1'b1;
              retries <= retries - 2'd1;
            end else begin
              retrying <= 1'b0;
              retries <= o_cfg1[bcie_pkg::C_TWICE] ? 2'd2 : 2'd1;
              frame_err <= frame_err || i_msg_rpt.error;
              frame_sts <= frame_sts || i_msg_rpt.unexp_sts;
              if (failed && halt_msg) begin
                st <= ST_IDLE;
                running <= 1'b0;
                frame_act <= 1'b0;
              end else if (i_msg_rpt.last) begin
                frame_act <= 1'b0;
                frame_err <= 1'b0;
                frame_sts <= 1'b0;
                if (auto_on && !halt_frame) begin
                  st <= ST_WAIT;
                end else begin
                  st <= ST_IDLE;
                  running <= 1'b0;
                end
              end
            end
          end
        end
        ST_WAIT: begin
          if (!auto_on) begin
            st <= ST_IDLE;
            running <= 1'b0;
          end else if (trig_go) begin
            st <= ST_MSG;
            frame_act <= 1'b1;
            msg_act <= 1'b1;
            o_msg_start <= 1'b1;
          end
        end
        default: st <= ST_IDLE;
      endcase
    end
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);
  sequence s_launch;
    st == ST_IDLE && bc_mode && start_cmd;
  endsequence
  sequence s_active;
    o_msg_start && o_cfg1[bcie_pkg::C_RUN] == 1'b0 ##1 o_cfg1[bcie_pkg::C_RUN];
  endsequence
  a_irq_raise: assert property (|(ev_eff & ien & bcie_pkg::IEN_EVMASK) |=> o_irq)
    else $error("enabled event gave no interrupt");
  a_irq_masked: assert property (!(|(i_events & ien)) && !do_retry && !i_msg_done |=> !o_irq)
    else $error("masked event gave interrupt");
  a_bit9_silent: assert property (ev_eff == 16'h0200 |=> !o_irq)
    else $error("bit 9 raised interrupt");
  a_ien_unused: assert property ((ien & ~bcie_pkg::IEN_WMASK) == 16'h0000)
    else $error("unused enable bit set");
  a_cfg_fixed: assert property (!o_cfg1[bcie_pkg::C_FIX0])
    else $error("bit 14 not zero");
  a_launch_seq: assert property (s_launch |=> s_active)
    else $error("start did not raise status");
  a_rt_blocks: assert property (st == ST_IDLE && !bc_mode |=> st == ST_IDLE)
    else $error("controller ran in rt mode");
  a_ext_off: assert property (st == ST_IDLE && !start_cmd && !o_cfg1[bcie_pkg::C_EXT]
                              |=> !o_msg_start)
    else $error("trigger acted while disabled");
  a_halt_clear: assert property (st == ST_MSG && i_msg_done && failed && halt_msg && !do_retry
                                 |=> ##1 o_cfg1[2:0] == 3'b000)
    else $error("halt left status set");
  a_msg_flag: assert property (o_msg_start |=> o_cfg1[bcie_pkg::C_MSG])
    else $error("message flag missing");

  // a frame that ends with no repeat to follow drops running two cycles on
  sequence s_frame_done;
    st == ST_MSG && i_msg_done && i_msg_rpt.last && !do_retry;
  endsequence
  sequence s_run_drop;
    ##1 !o_cfg1[bcie_pkg::C_RUN];
  endsequence
  a_auto_end: assert property (s_frame_done ##0 !auto_on |=> s_run_drop)
    else $error("running stayed set without auto repeat");
  a_err_frame: assert property (s_frame_done ##0
    (i_msg_rpt.error && o_cfg1[bcie_pkg::C_ERR_EOF]) |=> s_run_drop)
    else $error("frame error did not halt");
  a_sts_frame: assert property (s_frame_done ##0
    (i_msg_rpt.unexp_sts && o_cfg1[bcie_pkg::C_STS_EOF]) |=> s_run_drop)
    else $error("frame status did not halt");

  // timing and status guards: no message before its gap, frame time or a start or trigger edge; running held in wait, flags clear in idle
  a_gap_hold: assert property (st == ST_GAP && gap_cnt != 16'h0000 |=> !o_msg_start)
    else $error("message issued inside gap");
  a_frame_wait: assert property (st == ST_WAIT && o_cfg1[bcie_pkg::C_INT]
    && !o_cfg1[bcie_pkg::C_EXT] && frame_cnt < i_frame_len |=> !o_msg_start)
    else $error("frame started before its length");
  a_wait_run: assert property (st == ST_WAIT |=> o_cfg1[bcie_pkg::C_RUN])
    else $error("running dropped between frames");
  a_idle_flags: assert property (st == ST_IDLE
    |=> !o_cfg1[bcie_pkg::C_FRAME] && !o_cfg1[bcie_pkg::C_MSG])
    else $error("idle with frame or message flag set");
  a_ext_edge: assert property (st == ST_IDLE && !start_cmd
    && !(i_ext_trig && !ext_d) |=> !o_msg_start)
    else $error("frame started without start or trigger edge");

  // read, retry and frame counter guards
  a_retry_gate: assert property (st == ST_MSG && i_msg_done
    && !(o_cfg1[bcie_pkg::C_RETRY] && i_msg_rpt.retry_ctl) |=> !retrying)
    else $error("retry without both enables");
  a_frame_restart: assert property (o_msg_start && !o_cfg1[bcie_pkg::C_FRAME]
    |=> frame_cnt == 16'h0000)
    else $error("frame counter not restarted");
  a_ien_read: assert property (rd_act && i_addr == bcie_pkg::ADDR_IEN
    |=> o_rdata_oe && o_rdata == $past(ien))
    else $error("enable register read wrong");
endmodule

// >>> dv/bcie_host.sv
// host processor model driving the asynchronous register strobes
`timescale 1ns/10ps
module bcie_host (
  input wire logic i_mclk,
  input wire logic [15:0] i_rdata,
  output logic o_cs_n,
  output logic o_rd_n,
  output logic o_wr_n,
  output logic [4:0] o_addr,
  output logic [15:0] o_wdata
);
  // idle strobes high from time zero
  initial begin
    o_cs_n = 1'b1;
    o_rd_n = 1'b1;
    o_wr_n = 1'b1;
    o_addr = 5'h00;
    o_wdata = 16'h0000;
  end

  // one cycle, held to the sampling edge; released lines show inverted values
  task automatic cyc(input logic rd, input logic [4:0] a, input logic [15:0] d,
      output logic [15:0] q);
    @(posedge i_mclk);
    #1;
    o_cs_n = 1'b0;
    o_rd_n = !rd;
    o_wr_n = rd;
    o_addr = a;
    o_wdata = d;
    @(posedge i_mclk);
    #1;
    q = i_rdata; // registered answer of the sampled read
    o_cs_n = 1'b1;
    o_rd_n = 1'b1;
    o_wr_n = 1'b1;
    o_addr = ~a;
    o_wdata = ~d;
  endtask
endmodule

// >>> dv/bcie_regs_tb_top.sv
// self-checking bench for the enable and configuration registers
`timescale 1ns/10ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin miscompares++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module bcie_regs_tb_top;
  logic i_mclk, i_arst_n, cs_n, rd_n, wr_n, oe, enh, ext, done, mstart, irq;
  logic [4:0] addr;
  logic [15:0] wdata, rdata, events, flen, gap, cfg1, q;
  bcie_pkg::bcie_msg_rpt_t rpt;
  int checks = 0;
  int miscompares = 0;
  typedef struct packed {logic [4:0] a; logic [15:0] d; logic [15:0] q;} bcie_row_t;
  bcie_row_t rows[6] = '{'{5'h00, 16'hffff, 16'h33df}, '{5'h00, 16'h0200, 16'h0200},
    '{5'h01, 16'hffff, 16'hbff8}, '{5'h01, 16'h2000, 16'h2000},
    '{5'h02, 16'hffff, 16'h0000}, '{5'h01, 16'h0000, 16'h0000}};
  int evb[10] = '{13, 12, 8, 7, 6, 4, 3, 2, 1, 0};

  bcie_host host_u (.i_mclk(i_mclk), .i_rdata(rdata), .o_cs_n(cs_n), .o_rd_n(rd_n),
    .o_wr_n(wr_n), .o_addr(addr), .o_wdata(wdata));
  bcie_regs #(.STEP_CYCLES(20)) dut_u (.i_mclk(i_mclk), .i_arst_n(i_arst_n),
    .i_cs_n(cs_n), .i_rd_n(rd_n), .i_wr_n(wr_n), .i_addr(addr), .i_wdata(wdata),
    .o_rdata(rdata), .o_rdata_oe(oe), .i_events(events),
    .i_enhanced_mode_select_bit(enh), .i_ext_trig(ext), .i_frame_len(flen),
    .i_gap(gap), .i_msg_done(done), .i_msg_rpt(rpt), .o_cfg1(cfg1),
    .o_msg_start(mstart), .o_irq(irq));

  // free running 100 MHz clock
  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end

  task automatic complete_run();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    host_u.cyc(1'b0, a, d, q);
  endtask

  // event pulse of one cycle; interrupt level seen one cycle later
  task automatic ev(input logic [15:0] m, input logic e);
    events = m;
    @(posedge i_mclk);
    #1;
    events = 16'h0000;
    `CHK("irq", e, irq)
  endtask

  // message start must come between lo and hi cycles from now
  task automatic wstart(input int lo, input int hi);
    int n;
    n = 0;
    while (mstart !== 1'b1 && n < hi) begin
      @(posedge i_mclk);
      #1;
      n++;
    end
    `CHK("msg_start", 1'b1, (mstart === 1'b1 && n >= lo))
    if (mstart !== 1'b1) complete_run();
  endtask

  // status bits must reach e within a few cycles
  task automatic wcfg(input logic [2:0] e);
    int n;
    n = 0;
    while (cfg1[2:0] !== e && n < 6) begin
      @(posedge i_mclk);
      #1;
      n++;
    end
    `CHK("status", e, cfg1[2:0])
    if (cfg1[2:0] !== e) complete_run();
  endtask

  // core reports message end as {error, unexp_sts, retry_ctl, last}
  task automatic fin(input logic [3:0] r);
    done = 1'b1;
    rpt = r;
    @(posedge i_mclk);
    #1;
    done = 1'b0;
  endtask

  initial begin
    {i_arst_n, enh, ext, done} = 4'h0;
    {events, flen, gap} = '0;
    rpt = 4'h0;
    repeat (20) @(posedge i_mclk);
    #1;
    i_arst_n = 1'b1;
    // plain register rows: write then read back
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      `CHK("rdata_oe", 1'b0, oe)
      host_u.cyc(1'b1, rows[i].a, 16'h0000, q);
      `CHK("reg_read", rows[i].q, q)
      `CHK("rdata_oe", 1'b1, oe)
    end
    // reset in mid run clears the enable register
    wr(5'h00, 16'hffff);
    i_arst_n = 1'b0;
    repeat (2) @(posedge i_mclk);
    #1;
    i_arst_n = 1'b1;
    host_u.cyc(1'b1, 5'h00, 16'h0000, q);
    `CHK("ien_reset", 16'h0000, q)
    // each enabled event alone raises the interrupt; the rest stay masked
    foreach (evb[i]) begin
      wr(5'h00, 16'h0001 << evb[i]);
      ev(16'h0001 << evb[i], 1'b1);
      ev(16'h33df & ~(16'h0001 << evb[i]), 1'b0);
    end
    wr(5'h00, 16'h0200);
    ev(16'h0200, 1'b0);
    // host launch, one message frame, then idle; controller end of message interrupts
    wr(5'h00, 16'h0010);
    wr(5'h01, 16'h0000);
    wr(5'h03, 16'h0002);
    wstart(0, 5);
    wcfg(3'b111);
    fin(4'b0001);
    `CHK("eom_irq", 1'b1, irq)
    wcfg(3'b000);
    // stop on error with one retry: retry after default gap, second failure halts
    wr(5'h01, 16'h1010);
    wr(5'h03, 16'h0002);
    wstart(0, 5);
    fin(4'b1010);
    wstart(900, 1100);
    fin(4'b1010);
    wcfg(3'b000);
    // descriptor gap of three microseconds
    gap = 16'h0003;
    wr(5'h01, 16'h0020);
    wr(5'h03, 16'h0002);
    wstart(0, 5);
    fin(4'b0000);
    wstart(200, 400);
    fin(4'b0001);
    wcfg(3'b000);
    // stop on unexpected status halts at once
    wr(5'h01, 16'h0400);
    wr(5'h03, 16'h0002);
    wstart(0, 5);
    fin(4'b0100);
    wcfg(3'b000);
    // no retry without the message's own retry bit: the failure halts at once
    wr(5'h01, 16'h1010);
    wr(5'h03, 16'h0002);
    wstart(0, 5);
    fin(4'b1000);
    wcfg(3'b000);
    // retry twice: two re-issues after the default gap, the third failure halts
    wr(5'h01, 16'h1018);
    wr(5'h03, 16'h0002);
    wstart(0, 5);
    fin(4'b1010);
    wstart(900, 1100);
    fin(4'b1010);
    wstart(900, 1100);
    fin(4'b1010);
    wcfg(3'b000);
    // auto repeat on the internal frame counter, then an error ends it at frame end
    enh = 1'b1;
    flen = 16'h0002;
    wr(5'h01, 16'h0940);
    wr(5'h03, 16'h0002);
    wstart(0, 5);
    fin(4'b0001);
    wcfg(3'b100);
    wstart(10, 60);
    fin(4'b1001);
    wcfg(3'b000);
    // unexpected status with auto repeat and bit 9 starts no further frame
    wr(5'h01, 16'h0340);
    wr(5'h03, 16'h0002);
    wstart(0, 5);
    fin(4'b0101);
    wcfg(3'b000);
    // external trigger rising edge starts a frame
    wr(5'h01, 16'h0080);
    ext = 1'b1;
    wstart(0, 5);
    fin(4'b0001);
    wcfg(3'b000);
    complete_run();
  end
endmodule
